// >>> src/asfi_frame_if.sv
// Serial frame interface of the converter: framing, register writes, result word
`timescale 1ns/1ns
`default_nettype none
module asfi_frame_if
    import asfi_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                rst_n_i,
    // Serial pins from the host
    input  wire logic                sclk_i,
    input  wire logic                cs_n_i,
    input  wire logic                din_i,
    output logic                     dout_o,
    output logic                     dout_oe_o,
    // Conversion results from the converter core
    input  wire logic                conv_valid_i,
    output logic                     conv_ready_o,
    input  wire logic [CHAN_W-1:0]   conv_chan_i,
    input  wire logic                conv_sign_i,
    input  wire logic [MAG_W-1:0]    conv_mag_i,
    // Sampler and power control
    output logic                     hold_o,
    output logic                     shutdown_o,
    // Register contents
    output logic [CTRL_W-1:0]        ctrl_o,
    output logic [SHORT_W-1:0]       seq_o,
    output logic [SHORT_W-1:0]       range_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    // Bits are {sclk, cs_n, din}; idle is clock high, select high
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       sclk_last_r;
    logic       cs_last_r;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sync1_r     <= PINS_RST;
            sync2_r     <= PINS_RST;
            sclk_last_r <= 1'b1;
            cs_last_r   <= 1'b1;
        end else begin
            sync1_r     <= {sclk_i, cs_n_i, din_i};
            sync2_r     <= sync1_r;
            sclk_last_r <= sync2_r[2];
            cs_last_r   <= sync2_r[1];
        end
    end

    wire logic sclk_s    = sync2_r[2];
    wire logic cs_s      = sync2_r[1];
    wire logic din_s     = sync2_r[0];
    wire logic sclk_fall = sclk_last_r & ~sclk_s;
    wire logic sclk_rise = ~sclk_last_r & sclk_s;
    wire logic cs_fall   = cs_last_r & ~cs_s;
    wire logic cs_rise   = ~cs_last_r & cs_s;

    // ------------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------------
    // Two entries let the core post a result while a frame still shifts
    logic [RESULT_W-1:0] buf_data;
    logic                buf_valid;

    asfi_two_entry_buf #(
        .WIDTH (RESULT_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (conv_valid_i),
        .in_ready_o  (conv_ready_o),
        .in_data_i   ({conv_chan_i, conv_sign_i, conv_mag_i}),
        .out_valid_o (buf_valid),
        .out_ready_i (cs_fall),
        .out_data_o  (buf_data)
    );

    // An empty buffer sends an all-zero word rather than stale data
    wire logic [RESULT_W-1:0] result = buf_valid ? buf_data : '0;
    wire logic [FRAME_BITS-1:0] word_ld = {1'b0, result};

    // ------------------------------------------------------------------
    // Frame state and edge counters
    // ------------------------------------------------------------------
    logic             active_r;
    logic [CNT_W-1:0] fall_cnt_r;
    logic [CNT_W-1:0] rise_cnt_r;

    // Edges are honoured only while select stays low inside the frame
    wire logic             live     = active_r & ~cs_s;
    wire logic             fall_go  = live & sclk_fall & (fall_cnt_r != CNT_END);
    wire logic             rise_go  = live & sclk_rise & (rise_cnt_r != CNT_END);
    wire logic [CNT_W-1:0] fall_num = fall_cnt_r + CNT_ONE;
    wire logic [CNT_W-1:0] rise_num = rise_cnt_r + CNT_ONE;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            active_r   <= 1'b0;
            fall_cnt_r <= CNT_ZERO;
            rise_cnt_r <= CNT_ZERO;
        end else if (cs_fall) begin
            active_r   <= 1'b1;
            fall_cnt_r <= CNT_ZERO;
            rise_cnt_r <= CNT_ZERO;
        end else if (cs_rise) begin
            active_r   <= 1'b0;
        end else begin
            if (fall_go) begin
                fall_cnt_r <= fall_num;
            end
            if (rise_go) begin
                rise_cnt_r <= rise_num;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial input and register select
    // ------------------------------------------------------------------
    logic [FRAME_BITS-1:0] rx_r;
    logic [SEL_W-1:0]      sel_r;

    wire logic [FRAME_BITS-1:0] rx_nxt = {rx_r[FRAME_BITS-2:0], din_s};

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_r  <= '0;
            sel_r <= SEL_RST;
        end else if (fall_go) begin
            rx_r <= rx_nxt;
            if (fall_num == CNT_SEL_LAST) begin
                sel_r <= rx_nxt[SEL_W-1:0];
            end
        end
    end

    // Register data follow the selector, MSB first, up to the load edge
    wire logic [CTRL_W-1:0]  ctrl_data  = rx_nxt[CTRL_W-1:0];
    wire logic [SHORT_W-1:0] short_data = rx_nxt[SHORT_W-1:0];

    wire logic ctrl_ld = fall_go & (fall_num == CNT_CTRL_LD) & (sel_r == SEL_CTRL)
                       & ctrl_data[CTRL_WE_POS];
    wire logic short_ld = fall_go & (fall_num == CNT_SHORT_LD)
                        & short_data[SHORT_WE_POS];
    wire logic seq_ld   = short_ld & (sel_r == SEL_SEQ);
    wire logic range_ld = short_ld & (sel_r == SEL_RANGE);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // A frame aborted before its load edge (fall 11 or 15) leaves contents put
    logic ctrl_wr_r;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_o    <= CTRL_RST;
            seq_o     <= SHORT_RST;
            range_o   <= SHORT_RST;
            ctrl_wr_r <= 1'b0;
        end else begin
            if (ctrl_ld) begin
                ctrl_o <= ctrl_data;
            end
            if (seq_ld) begin
                seq_o <= short_data;
            end
            if (range_ld) begin
                range_o <= short_data;
            end
            if (cs_fall) begin
                ctrl_wr_r <= 1'b0;
            end else if (ctrl_ld) begin
                ctrl_wr_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power mode change
    // ------------------------------------------------------------------
    // Takes effect only on rise fifteen of the frame that wrote control
    wire logic pwr_edge = rise_go & (rise_num == CNT_PWR) & ctrl_wr_r;
    wire logic pwr_full = ctrl_o[POWER_HI_POS] & ctrl_o[POWER_LO_POS];

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            shutdown_o <= 1'b0;
        end else if (pwr_edge) begin
            shutdown_o <= pwr_full;
        end
    end

    // ------------------------------------------------------------------
    // Track and hold
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            hold_o <= 1'b0;
        end else if (cs_fall) begin
            hold_o <= 1'b1;
        end else if (cs_rise) begin
            hold_o <= 1'b0;
        end else if (rise_go && (rise_num == CNT_TRACK)) begin
            hold_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    // The zero bit leaves with select; later bits follow falling edges
    logic [FRAME_BITS-1:0] tx_r;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_r      <= '0;
            dout_o    <= 1'b0;
            dout_oe_o <= 1'b0;
        end else if (cs_fall) begin
            tx_r      <= word_ld;
            dout_o    <= word_ld[FRAME_BITS-1];
            dout_oe_o <= 1'b1;
        end else if (cs_rise) begin
            dout_oe_o <= 1'b0;
        end else if (fall_go) begin
            tx_r   <= {tx_r[FRAME_BITS-2:0], 1'b0};
            dout_o <= tx_r[FRAME_BITS-2];
            if (fall_num == CNT_END) begin
                dout_oe_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// >>> src/asfi_pkg.sv
// Constants for the converter serial frame interface
package asfi_pkg;

    // ------------------------------------------------------------------
    // Field widths
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned SEL_W      = 3;
    localparam int unsigned CTRL_W     = 12;
    localparam int unsigned SHORT_W    = 8;
    localparam int unsigned MAG_W      = 12;
    localparam int unsigned CHAN_W     = 2;
    localparam int unsigned RESULT_W   = CHAN_W + 1 + MAG_W;

    // ------------------------------------------------------------------
    // Edge counts within a frame
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_SEL_LAST = 5'h03;
    localparam logic [CNT_W-1:0] CNT_SHORT_LD = 5'h0B;
    localparam logic [CNT_W-1:0] CNT_TRACK    = 5'h0E;
    localparam logic [CNT_W-1:0] CNT_CTRL_LD  = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_PWR      = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_END      = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE      = 5'h01;

    // ------------------------------------------------------------------
    // Register selector codes and field positions
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_CTRL  = 3'h0;
    localparam logic [SEL_W-1:0] SEL_SEQ   = 3'h1;
    localparam logic [SEL_W-1:0] SEL_RANGE = 3'h2;

    localparam int unsigned CTRL_WE_POS     = 11;
    localparam int unsigned SHORT_WE_POS    = 7;
    localparam int unsigned POWER_HI_POS    = 5;
    localparam int unsigned POWER_LO_POS    = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CTRL_W-1:0]   CTRL_RST   = 12'h000;
    localparam logic [SHORT_W-1:0]  SHORT_RST  = 8'h00;
    localparam logic [SEL_W-1:0]    SEL_RST    = 3'h0;
    localparam logic [2:0]          PINS_RST   = 3'h6;

    localparam int unsigned BUF_DEPTH = 2;

endpackage

// >>> src/asfi_two_entry_buf.sv
// Small valid/ready buffer for conversion results
`timescale 1ns/1ns
`default_nettype none
module asfi_two_entry_buf
    import asfi_pkg::*;
#(
    parameter int unsigned WIDTH = 15,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0]   cnt_r;
    logic [PTR_W:0]   cnt_nxt;
    logic             not_full_r;
    logic             not_empty_r;
    wire logic        push = in_valid_i & not_full_r;
    wire logic        pop  = out_ready_i & not_empty_r;

    // ------------------------------------------------------------------
    // Flags kept in flip-flops so both sides see clean levels
    // ------------------------------------------------------------------
    assign cnt_nxt     = cnt_r + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
    assign in_ready_o  = not_full_r;
    assign out_valid_o = not_empty_r;
    assign out_data_o  = mem_r[rd_ptr_r];

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            cnt_r       <= '0;
            not_full_r  <= 1'b1;
            not_empty_r <= 1'b0;
        end else begin
            cnt_r       <= cnt_nxt;
            not_full_r  <= (cnt_nxt != CNT_FULL);
            not_empty_r <= (cnt_nxt != '0);
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // Storage needs no reset; the flags guard every read
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

endmodule
`default_nettype wire

// >>> tb/asfi_frame_if_monitor.sv
// Concurrent checks on the ports of the converter serial frame interface
`timescale 1ns/1ns
`default_nettype none
module asfi_frame_if_monitor
    import asfi_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              rst_n_i,
    input wire logic              sclk_i,
    input wire logic              cs_n_i,
    input wire logic              din_i,
    input wire logic              dout_o,
    input wire logic              dout_oe_o,
    input wire logic              conv_valid_i,
    input wire logic              conv_ready_o,
    input wire logic [CHAN_W-1:0] conv_chan_i,
    input wire logic              conv_sign_i,
    input wire logic [MAG_W-1:0]  conv_mag_i,
    input wire logic              hold_o,
    input wire logic              shutdown_o,
    input wire logic [CTRL_W-1:0] ctrl_o,
    input wire logic [SHORT_W-1:0] seq_o,
    input wire logic [SHORT_W-1:0] range_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Falls seen on the pin inside the current frame
    // ------------------------------------------------------------
    logic       sclk_last_r;
    logic [4:0] falls_r;

    always_ff @(posedge core_clk_i) begin
        sclk_last_r <= sclk_i;
        if (cs_n_i) begin
            falls_r <= 5'h00;
        end else if (sclk_last_r && !sclk_i && (falls_r != 5'h1F)) begin
            falls_r <= falls_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Pin edges pass a two-stage sync, so every bound allows 3 clocks
    frame_start_a: assert property ($fell(cs_n_i) |->
        ##[2:5] (dout_oe_o && !dout_o && hold_o))
        else $error("Frame start did not enable output in hold");
    abort_release_a: assert property ($rose(cs_n_i) |->
        ##[1:5] (!dout_oe_o && !hold_o))
        else $error("Chip select rise did not release output");
    hold_track_a: assert property ($fell(hold_o) |->
        $past(sclk_i, 3) || $past(cs_n_i, 3))
        else $error("Sampler left hold away from a rising edge");
    oe_end_a: assert property ($fell(dout_oe_o) |->
        !$past(sclk_i, 3) || $past(cs_n_i, 3))
        else $error("Output released away from a falling edge");
    end_release_a: assert property ((falls_r == 5'h10) [*5] |->
        !dout_oe_o && !hold_o)
        else $error("Output or hold still active after the last falling edge");
    ctrl_load_a: assert property ($changed(ctrl_o) |->
        !$past(sclk_i, 3) && !$past(cs_n_i, 3))
        else $error("Control register changed outside a falling edge");
    short_load_a: assert property (($changed(seq_o) || $changed(range_o)) |->
        !$past(sclk_i, 3) && !$past(cs_n_i, 3))
        else $error("Short register changed outside a falling edge");
    power_edge_a: assert property ($changed(shutdown_o) |->
        $past(sclk_i, 3) && !$past(cs_n_i, 3))
        else $error("Shutdown changed away from a rising edge");
    idle_quiet_a: assert property (cs_n_i [*6] |-> !dout_oe_o && !hold_o)
        else $error("Output or hold active outside a frame");
    dout_hold_a: assert property ((sclk_i && !cs_n_i) [*6] |=> $stable(dout_o))
        else $error("Output bit changed without a falling edge");
    cover property ($rose(shutdown_o));
    cover property ($fell(conv_ready_o));
    cover property ($rose(cs_n_i) && hold_o);
endmodule
bind asfi_frame_if asfi_frame_if_monitor i_mon (.core_clk_i, .rst_n_i, .sclk_i, .cs_n_i, .din_i,
    .dout_o, .dout_oe_o, .conv_valid_i, .conv_ready_o, .conv_chan_i, .conv_sign_i, .conv_mag_i,
    .hold_o, .shutdown_o, .ctrl_o, .seq_o, .range_o);
`default_nettype wire

// >>> tb/asfi_host_model.sv
// Host serial port model that frames words into the converter interface
`timescale 1ns/1ns
`default_nettype none
module asfi_host_model (
    input  wire logic core_clk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output var logic  sclk_o,
    output var logic  cs_n_o,
    output var logic  din_o
);
    logic last_r;
    logic line;
    // Released line flips every cycle so a stale bit never reads as valid
    assign line = dout_oe_i ? dout_i : ~last_r;
    always @(posedge core_clk_i) last_r <= line;
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
        last_r = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // ------------------------------------------------------------
    // One frame; fewer than 16 falls aborts it
    // ------------------------------------------------------------
    // Link clock runs at 125 ns, 63 ns low and 62 ns high; its edges
    // land 1, 4, 6 or 9 ns past a core edge, never on one
    task automatic frame(input logic [15:0] tx, input int nf, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_o <= 1'b0;
        din_o  <= tx[15];
        wait_cyc(7);
        #6;
        for (int i = 0; i < nf; i++) begin
            sclk_o = 1'b0;
            rx[15-i] = line;
            #63;
            sclk_o = 1'b1;
            din_o  = (i < 15) ? tx[14-i] : 1'b0;
            #62;
        end
        @(posedge core_clk_i);
        cs_n_o <= 1'b1;
        // Gap also covers the power-up time after an auto-standby frame
        wait_cyc(76);
    endtask
endmodule
`default_nettype wire

// >>> tb/asfi_frame_if_tb.sv
// Self-checking bench of the converter serial frame interface
`timescale 1ns/1ns
`default_nettype none
module asfi_frame_if_tb;
    import asfi_pkg::*;
    logic        clk, rst_n, sclk, cs_n, din, dout, dout_oe;
    logic        conv_valid, conv_ready, conv_sign, hold, shutdown;
    logic [1:0]  conv_chan;
    logic [11:0] conv_mag, ctrl, exp_ctrl;
    logic [7:0]  seq, rng, exp_seq, exp_rng;
    logic        exp_sd;
    logic [14:0] q[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    asfi_frame_if i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .conv_valid_i(conv_valid),
        .conv_ready_o(conv_ready), .conv_chan_i(conv_chan), .conv_sign_i(conv_sign),
        .conv_mag_i(conv_mag), .hold_o(hold), .shutdown_o(shutdown), .ctrl_o(ctrl),
        .seq_o(seq), .range_o(rng));
    asfi_host_model i_host (.core_clk_i(clk), .dout_i(dout), .dout_oe_i(dout_oe),
        .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    // Valid stays up across words so it is never driven twice in a step
    task automatic push(input int n);
        logic [14:0] w;
        for (int k = 0; k < n; k++) begin
            w = 15'($urandom);
            {conv_chan, conv_sign, conv_mag} <= w;
            conv_valid <= 1'b1;
            for (int t = 0; t < 20; t++) begin
                @(posedge clk);
                if (conv_ready === 1'b1) break;
            end
            q.push_back(w);
        end
        conv_valid <= 1'b0;
    endtask
    task automatic run(input int sel, input bit we, input int nf, input int pm);
        logic [11:0] d;
        logic [15:0] tx, rx, ex;
        d = 12'($urandom);
        if (sel == 0) begin
            d[11] = we;
            if (pm >= 0) d[5:4] = 2'(pm);
            tx = {3'(sel), d, 1'b0};
        end else begin
            d[7] = we;
            tx = {3'(sel), d[7:0], 5'h00};
        end
        ex = (q.size() > 0) ? {1'b0, q.pop_front()} : 16'h0000;
        i_host.frame(tx, nf, rx);
        if (we && sel == 0 && nf >= 15) begin
            exp_ctrl = d;
            exp_sd = d[5] & d[4];
        end
        if (we && sel == 1 && nf >= 11) exp_seq = d[7:0];
        if (we && sel == 2 && nf >= 11) exp_rng = d[7:0];
        if (nf == 16) chk(rx, ex, "result word");
        chk(16'(ctrl), 16'(exp_ctrl), "control");
        chk({seq, rng}, {exp_seq, exp_rng}, "sequence or range");
        chk(16'({hold, dout_oe, shutdown}), 16'({2'b00, exp_sd}), "pins");
    endtask
    initial begin
        {conv_valid, conv_chan, conv_sign, conv_mag} = '0;
        rst_n = 1'b0;
        {exp_ctrl, exp_seq, exp_rng, exp_sd} = '0;
        void'($urandom(82));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({conv_ready, ctrl, dout_oe, hold, shutdown}, 16'h8000, "reset state");
        chk({seq, rng}, 16'h0000, "reset registers");
        push(2);
        repeat (2) @(posedge clk);
        chk(16'(conv_ready), 16'h0000, "buffer full");
        run(0, 1, 16, -1);
        run(1, 1, 16, -1);
        run(2, 1, 16, -1);
        for (int s = 3; s < 8; s++) run(s, 1, 16, -1);
        run(1, 0, 16, -1);
        run(0, 0, 16, -1);
        push(1);
        run(1, 1, 10, -1);
        run(2, 1, 12, -1);
        run(0, 1, 16, 3);
        run(0, 1, 16, 0);
        run(0, 1, 16, 3);
        run(0, 1, 16, 2);
        for (int k = 0; k < 6; k++) begin
            push(1);
            run($urandom_range(2), 1'($urandom_range(1)), 16, -1);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
